// >>> cmr_pkg.sv
// Functional notes
// - mode0 bit7: init queue on entering slave or polling run
// - mode0 bit6 enables clock output, reset on
// - mode0 bit5: sync timeout returns to polling
// - mode0 bit4: lock queue at message end
// - slave mode: bit3 picks config A/B
// - polling mode: bit2 enables A-then-B use
// - slave/sleep: bit1 sleep or slave run
// - mode0 bit0: slave/sleep or self polling
// - mode1 bit6: hold config state in slave run
// - mode1 bit5: irq polarity low or high
// - mode1 bit4 enables crystal trimming
// - mode1 bit3: init queue at frame start
// - mode1 bit2: clock or data on pin
// - mode1 bit1: irq or strobe on pin
// - mode1 bit0: run or data on pin
// - flags bits 7..4 hold config B events
// - flags bits 3..0 hold config A events
// - reset sets all flag bits to one
// - mask bit 1 keeps flag from irq
package cmr_pkg;
   localparam logic [7:0] CMR_TRACE_ADDR_OFS = 8'h00;
   localparam logic [7:0] CMR_TRACE_DATA_OFS = 8'h01;
   localparam logic [7:0] CMR_MODE0_OFS = 8'h02;
   localparam logic [7:0] CMR_MODE1_OFS = 8'h03;
   localparam logic [7:0] CMR_FLAGS_OFS = 8'h04;
   localparam logic [7:0] CMR_MASK_OFS = 8'h05;
   localparam logic [7:0] CMR_MODE0_RST = 8'h40;
   localparam logic [7:0] CMR_MODE1_RST = 8'h00;
   localparam logic [7:0] CMR_FLAGS_RST = 8'hff;
   localparam logic [7:0] CMR_MASK_RST = 8'h00;
   localparam logic [7:0] CMR_TRACE_RST = 8'h00;
   // mode0 fields
   localparam int CMR_B_CYC_INIT = 7;
   localparam int CMR_B_CLK_ON = 6;
   localparam int CMR_B_TO_ON = 5;
   localparam int CMR_B_LOCK = 4;
   localparam int CMR_B_SLV_CFG = 3;
   localparam int CMR_B_DUAL = 2;
   localparam int CMR_B_SLV_RX = 1;
   localparam int CMR_B_OPMODE = 0;
   // mode1 fields
   localparam int CMR_B_HOLD = 6;
   localparam int CMR_B_IRQ_POL = 5;
   localparam int CMR_B_XTAL = 4;
   localparam int CMR_B_FS_INIT = 3;
   localparam int CMR_B_CLK_PIN = 2;
   localparam int CMR_B_IRQ_PIN = 1;
   localparam int CMR_B_RUN_PIN = 0;
   // flag fields (A low nibble, B high nibble)
   localparam int CMR_F_WAKE = 0;
   localparam int CMR_F_SYNC = 1;
   localparam int CMR_F_MID = 2;
   localparam int CMR_F_EOM = 3;
   localparam int CMR_F_CFG_B = 4;
   // sync timeout in microseconds and cycles at 100 MHz
   localparam int CMR_CLK_MHZ = 100;
   localparam int CMR_SYNC_TO_US = 100;
   localparam int CMR_SYNC_TO_CYC = CMR_SYNC_TO_US * CMR_CLK_MHZ;
   typedef enum logic [1:0] {
      CMR_SLEEP = 2'b00,
      CMR_SLAVE_RUN = 2'b01,
      CMR_POLL = 2'b10,
      CMR_POLL_RUN = 2'b11
   } cmr_state_t;
endpackage

// >>> cmr_sync3.sv
// three-stage synchroniser for a vector of pin inputs; change counts once stages 2 and 3 agree
module cmr_sync3 #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // pins in and clean out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   genvar i;
   // per-bit chain and agreement filter
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               s1_reg[i] <= 1'b0;
               s2_reg[i] <= 1'b0;
               s3_reg[i] <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               s1_reg[i] <= din[i];
               s2_reg[i] <= s1_reg[i];
               s3_reg[i] <= s2_reg[i];
               if (s2_reg[i] == s3_reg[i]) begin
                  dout[i] <= s3_reg[i];
               end
            end
         end
      end
   endgenerate
endmodule

// >>> cmr_regs.sv
// mode and interrupt status register bank with APB slave
//
// Implementation choice: the APB register port.
module cmr_regs
   import cmr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // receiver event pulses, same clock: [7:4] config B, [3:0] config A
   input wire logic [7:0] event_in,
   // receiver status from pins
   input wire logic cycle_start,
   input wire logic frame_start,
   input wire logic sync_found,
   input wire logic rx_data,
   input wire logic rx_strobe,
   input wire logic clk_src,
   // serial interface traffic, same clock
   input wire logic ser_addr_valid,
   input wire logic [7:0] ser_addr,
   input wire logic ser_data_valid,
   input wire logic [7:0] ser_data,
   // receiver control
   output logic queue_init,
   output logic queue_lock_en,
   output logic use_cfg_b,
   output logic rx_running,
   output logic cfg_hold,
   output logic crystal_trim_on,
   output logic [1:0] rx_state,
   // shared pins
   output logic clock_data_pin,
   output logic irq_strobe_pin,
   output logic run_data_pin
);
   logic [7:0] chip_mode_control_0_reg;
   logic [7:0] chip_mode_control_1_reg;
   logic [7:0] interrupt_flags_reg;
   logic [7:0] irq_mask_reg;
   logic [7:0] serial_address_trace_reg;
   logic [7:0] serial_data_trace_reg;
   logic [31:0] prdata_reg;
   logic clock_data_reg;
   logic irq_strobe_reg;
   logic run_data_reg;
   logic queue_init_reg;
   logic cfg_b_phase_reg;
   logic [31:0] to_cnt_reg;
   cmr_state_t state_reg;
   cmr_state_t state_next;
   logic [5:0] pins_raw;
   logic [5:0] pins_s;
   logic cyc_s;
   logic frm_s;
   logic sync_s;
   logic rxd_s;
   logic stb_s;
   logic clk_s;
   logic wr_en;
   logic rd_en;
   logic irq_active;
   logic irq_level;
   logic timeout_hit;
   logic cyc_prev_reg;
   logic frm_prev_reg;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
      addr_hit = (a[7:2] == ofs[5:0]) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = addr_hit(a, CMR_TRACE_ADDR_OFS) || addr_hit(a, CMR_TRACE_DATA_OFS) ||
                   addr_hit(a, CMR_MODE0_OFS) || addr_hit(a, CMR_MODE1_OFS) ||
                   addr_hit(a, CMR_FLAGS_OFS) || addr_hit(a, CMR_MASK_OFS);
   endfunction

   // pin inputs from outside the clock domain
   assign pins_raw = {clk_src, rx_strobe, rx_data, sync_found, frame_start, cycle_start};
   cmr_sync3 #(.W(6)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .din(pins_raw),
      .dout(pins_s)
   );
   assign cyc_s = pins_s[0];
   assign frm_s = pins_s[1];
   assign sync_s = pins_s[2];
   assign rxd_s = pins_s[3];
   assign stb_s = pins_s[4];
   assign clk_s = pins_s[5];

   // apb strobes: zero-wait, error on unmapped word
   assign wr_en = psel && penable && pwrite && known_addr(paddr);
   assign rd_en = psel && penable && !pwrite && known_addr(paddr);
   assign pready = psel && penable;
   assign pslverr = psel && penable && !known_addr(paddr);
   assign prdata = prdata_reg;

   // mode and mask registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         chip_mode_control_0_reg <= CMR_MODE0_RST;
         chip_mode_control_1_reg <= CMR_MODE1_RST;
         irq_mask_reg <= CMR_MASK_RST;
      end else if (wr_en) begin
         if (addr_hit(paddr, CMR_MODE0_OFS)) begin
            chip_mode_control_0_reg <= pwdata[7:0];
         end
         if (addr_hit(paddr, CMR_MODE1_OFS)) begin
            chip_mode_control_1_reg <= pwdata[7:0];
         end
         if (addr_hit(paddr, CMR_MASK_OFS)) begin
            irq_mask_reg <= pwdata[7:0];
         end
      end
   end

   // interrupt flags: reset to ones, cleared by read, event wins over clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         interrupt_flags_reg <= CMR_FLAGS_RST;
      end else if (rd_en && addr_hit(paddr, CMR_FLAGS_OFS)) begin
         interrupt_flags_reg <= event_in;
      end else begin
         interrupt_flags_reg <= interrupt_flags_reg | event_in;
      end
   end

   // serial traffic tracers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         serial_address_trace_reg <= CMR_TRACE_RST;
         serial_data_trace_reg <= CMR_TRACE_RST;
      end else begin
         if (ser_addr_valid) begin
            serial_address_trace_reg <= ser_addr;
         end
         if (ser_data_valid) begin
            serial_data_trace_reg <= ser_data;
         end
      end
   end

   // read data register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= 32'h0000_0000;
         if (addr_hit(paddr, CMR_TRACE_ADDR_OFS)) begin
            prdata_reg <= {24'h00_0000, serial_address_trace_reg};
         end
         if (addr_hit(paddr, CMR_TRACE_DATA_OFS)) begin
            prdata_reg <= {24'h00_0000, serial_data_trace_reg};
         end
         if (addr_hit(paddr, CMR_FLAGS_OFS)) begin
            prdata_reg <= {24'h00_0000, interrupt_flags_reg | event_in};
         end
      end
   end

   // operating mode state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CMR_SLEEP, CMR_SLAVE_RUN: begin
            if (chip_mode_control_0_reg[CMR_B_OPMODE]) begin
               state_next = CMR_POLL;
            end else if (chip_mode_control_0_reg[CMR_B_SLV_RX]) begin
               state_next = CMR_SLAVE_RUN;
            end else begin
               state_next = CMR_SLEEP;
            end
         end
         CMR_POLL: begin
            if (!chip_mode_control_0_reg[CMR_B_OPMODE]) begin
               state_next = CMR_SLEEP;
            end else if (interrupt_flags_reg[CMR_F_WAKE] == 1'b0 &&
                         (event_in[CMR_F_WAKE] || event_in[CMR_F_CFG_B + CMR_F_WAKE])) begin
               state_next = CMR_POLL_RUN;
            end else if (event_in[CMR_F_WAKE] || event_in[CMR_F_CFG_B + CMR_F_WAKE]) begin
               state_next = CMR_POLL_RUN;
            end
         end
         CMR_POLL_RUN: begin
            if (!chip_mode_control_0_reg[CMR_B_OPMODE]) begin
               state_next = CMR_SLEEP;
            end else if (timeout_hit) begin
               state_next = CMR_POLL;
            end
         end
         default: begin
            state_next = CMR_SLEEP;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= CMR_SLEEP;
      end else begin
         state_reg <= state_next;
      end
   end

   // sync timeout counter in polling-initiated run
   assign timeout_hit = chip_mode_control_0_reg[CMR_B_TO_ON] &&
                        (to_cnt_reg >= 32'(CMR_SYNC_TO_CYC - 1));
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         to_cnt_reg <= 32'h0000_0000;
      end else if (state_reg != CMR_POLL_RUN || sync_s) begin
         to_cnt_reg <= 32'h0000_0000;
      end else if (!timeout_hit) begin
         to_cnt_reg <= to_cnt_reg + 32'h0000_0001;
      end
   end

   // dual configuration phase: A first, then toggled at each synced cycle start while polling
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfg_b_phase_reg <= 1'b0;
      end else if (state_reg != CMR_POLL && state_reg != CMR_POLL_RUN) begin
         cfg_b_phase_reg <= 1'b0;
      end else if (chip_mode_control_0_reg[CMR_B_DUAL] && cyc_s && !cyc_prev_reg) begin
         cfg_b_phase_reg <= ~cfg_b_phase_reg;
      end
   end

   // previous synced start levels, so a long start pulse acts once
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cyc_prev_reg <= 1'b0;
         frm_prev_reg <= 1'b0;
      end else begin
         cyc_prev_reg <= cyc_s;
         frm_prev_reg <= frm_s;
      end
   end

   // queue initialisation pulse
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         queue_init_reg <= 1'b0;
      end else begin
         queue_init_reg <=
            (chip_mode_control_0_reg[CMR_B_CYC_INIT] &&
             ((state_reg == CMR_SLEEP && state_next == CMR_SLAVE_RUN) ||
              (state_reg == CMR_POLL && state_next == CMR_POLL_RUN))) ||
            (chip_mode_control_1_reg[CMR_B_FS_INIT] && frm_s && !frm_prev_reg);
      end
   end

   // receiver controls
   assign queue_init = queue_init_reg;
   assign queue_lock_en = chip_mode_control_0_reg[CMR_B_LOCK];
   assign use_cfg_b = (state_reg == CMR_SLAVE_RUN || state_reg == CMR_SLEEP) ?
                      chip_mode_control_0_reg[CMR_B_SLV_CFG] :
                      (chip_mode_control_0_reg[CMR_B_DUAL] && cfg_b_phase_reg);
   assign rx_running = (state_reg == CMR_SLAVE_RUN) || (state_reg == CMR_POLL_RUN);
   assign cfg_hold = (state_reg == CMR_SLAVE_RUN) &&
                     chip_mode_control_1_reg[CMR_B_HOLD];
   assign crystal_trim_on = chip_mode_control_1_reg[CMR_B_XTAL];
   assign rx_state = state_reg;

   // interrupt level from unmasked flags
   assign irq_active = |(interrupt_flags_reg & ~irq_mask_reg);
   assign irq_level = chip_mode_control_1_reg[CMR_B_IRQ_POL] ? irq_active : ~irq_active;

   // shared output pins, registered
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         clock_data_reg <= 1'b0;
         irq_strobe_reg <= 1'b1;
         run_data_reg <= 1'b0;
      end else begin
         clock_data_reg <= chip_mode_control_1_reg[CMR_B_CLK_PIN] ? rxd_s :
                           (clk_s && chip_mode_control_0_reg[CMR_B_CLK_ON]);
         irq_strobe_reg <= chip_mode_control_1_reg[CMR_B_IRQ_PIN] ? stb_s : irq_level;
         run_data_reg <= chip_mode_control_1_reg[CMR_B_RUN_PIN] ? rxd_s : rx_running;
      end
   end
   assign clock_data_pin = clock_data_reg;
   assign irq_strobe_pin = irq_strobe_reg;
   assign run_data_pin = run_data_reg;
endmodule

// >>> cmr_regs_assertions.sv
// port-level checks of the mode and status register bank
module cmr_regs_assertions
   import cmr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // receiver control and shared pins
   input wire logic queue_lock_en,
   input wire logic use_cfg_b,
   input wire logic cfg_hold,
   input wire logic crystal_trim_on,
   input wire logic rx_running,
   input wire logic [1:0] rx_state,
   input wire logic irq_strobe_pin,
   input wire logic run_data_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [7:0] m0_reg, m1_reg, mask_reg;
   logic wr_acc;
   assign wr_acc = psel && penable && pwrite && pready;
   // shadow copies of the write-only registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         m0_reg <= CMR_MODE0_RST;
         m1_reg <= CMR_MODE1_RST;
         mask_reg <= CMR_MASK_RST;
      end else if (wr_acc) begin
         if (paddr == (CMR_MODE0_OFS << 2)) m0_reg <= pwdata[7:0];
         if (paddr == (CMR_MODE1_OFS << 2)) m1_reg <= pwdata[7:0];
         if (paddr == (CMR_MASK_OFS << 2)) mask_reg <= pwdata[7:0];
      end
   end
   AST_PREADY: assert property (psel && penable |-> pready && prdata[31:8] == 24'h0)
      else $error("access phase without zero-wait answer");
   AST_SLVERR: assert property (psel && penable && paddr[1:0] == 2'b00 && paddr[7:2] > 6'd5
      |-> pslverr) else $error("unmapped word not refused");
   AST_LOCK: assert property (queue_lock_en == m0_reg[4])
      else $error("queue lock enable differs from mode bit");
   AST_TRIM: assert property (crystal_trim_on == m1_reg[4])
      else $error("crystal trim differs from mode bit");
   AST_CFG: assert property (rx_state == CMR_SLAVE_RUN |-> use_cfg_b == m0_reg[3])
      else $error("slave config pick not followed");
   AST_HOLD: assert property (cfg_hold == (m1_reg[6] && rx_state == CMR_SLAVE_RUN))
      else $error("config hold wrong");
   AST_SLEEP: assert property (m0_reg[1:0] == 2'b00 && $past(m0_reg[1:0]) == 2'b00
      |-> rx_state == CMR_SLEEP) else $error("receiver not asleep");
   AST_SLVRUN: assert property (m0_reg[1:0] == 2'b10 && $past(m0_reg[1:0]) == 2'b10 &&
      $past(m0_reg[1:0], 2) == 2'b10 |-> rx_state == CMR_SLAVE_RUN)
      else $error("receiver not in slave run");
   AST_IRQ: assert property ($past(mask_reg) == 8'hff && !$past(m1_reg[1])
      |-> irq_strobe_pin == !$past(m1_reg[5])) else $error("masked irq pin level wrong");
   AST_RUN: assert property (!$past(m1_reg[0]) |-> run_data_pin == $past(rx_running))
      else $error("run pin does not follow running state");
   // main scenarios reached
   CV_SLVRUN_HOLD: cover property (rx_state == CMR_SLAVE_RUN ##1 cfg_hold);
   CV_REFUSED: cover property (psel && penable && pslverr);
   CV_POLL: cover property (rx_state == CMR_POLL);
   CV_POLL_RUN: cover property (rx_state == CMR_POLL ##1 rx_state == CMR_POLL_RUN);
endmodule

bind cmr_regs cmr_regs_assertions chk_u (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .queue_lock_en, .use_cfg_b, .cfg_hold,
   .crystal_trim_on, .rx_running, .rx_state, .irq_strobe_pin, .run_data_pin);

// >>> cmr_host_model.sv
// host controller side: apb master issuing one transfer at a time
module cmr_host_model (
   // clock
   input wire logic clock,
   // apb master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // setup, then hold the access until pready, bounded wait
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err, output logic hung);
      hung = 1'b1;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (int n = 0; n < 16; n++) begin
         @(posedge clock);
         if (pready === 1'b1) begin
            rd = prdata;
            err = pslverr;
            hung = 1'b0;
            break;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// >>> cmr_regs_tb_top.sv
// self-checking bench for the mode and status register bank
module cmr_regs_tb_top
   import cmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] A_TA = CMR_TRACE_ADDR_OFS << 2;
   localparam logic [7:0] A_TD = CMR_TRACE_DATA_OFS << 2;
   localparam logic [7:0] A_M0 = CMR_MODE0_OFS << 2;
   localparam logic [7:0] A_M1 = CMR_MODE1_OFS << 2;
   localparam logic [7:0] A_FL = CMR_FLAGS_OFS << 2;
   localparam logic [7:0] A_MK = CMR_MASK_OFS << 2;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, last_err, hung;
   logic [7:0] paddr, event_in = 8'h00, ser_addr = 8'h00, ser_data = 8'h00;
   logic [31:0] pwdata, prdata, rdat;
   logic ser_addr_valid = 1'b0, ser_data_valid = 1'b0, rx_data = 1'b0, rx_strobe = 1'b0;
   logic cycle_start = 1'b0, sync_found = 1'b0, clk_src = 1'b0, frame_start = 1'b0;
   logic queue_init, queue_lock_en, use_cfg_b, rx_running, cfg_hold, crystal_trim_on;
   logic clock_data_pin, irq_strobe_pin, run_data_pin;
   logic [1:0] rx_state;
   logic [7:0] m0v [4] = '{8'h12, 8'h0a, 8'h01, 8'h00};
   logic [3:0] mexp [4] = '{4'b0110, 4'b0101, 4'b1000, 4'b0000};
   int error_cnt = 0;
   int cmp_count = 0;
   int k;
   always #5 clock = ~clock;
   cmr_host_model host_u (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   cmr_regs dut_u (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .event_in, .cycle_start, .frame_start, .sync_found, .rx_data,
      .rx_strobe, .clk_src, .ser_addr_valid, .ser_addr, .ser_data_valid, .ser_data,
      .queue_init, .queue_lock_en, .use_cfg_b, .rx_running, .cfg_hold, .crystal_trim_on,
      .rx_state, .clock_data_pin, .irq_strobe_pin, .run_data_pin);
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      host_u.xfer(w, a, {24'h0, d}, rdat, last_err, hung);
      if (hung) begin
         error_cnt++;
         test_done();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 8'h00);
      chk(rdat, exp);
   endtask
   // let registered outputs settle before sampling
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // hang guard
   initial begin
      repeat (50000) @(posedge clock);
      error_cnt++;
      test_done();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rd(A_FL, 32'hff);
      rd(A_FL, 32'h0);
      rd(A_TA, 32'h0);
      rd(A_TD, 32'h0);
      rd(A_M0, 32'h0);
      rd(8'h18, 32'h0);
      chk(32'(last_err), 32'h1);
      // each event sets only its own flag
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         event_in <= 8'h01 << i;
         @(posedge clock);
         event_in <= 8'h00;
         rd(A_FL, 32'h1 << i);
      end
      // serial traffic captured by tracers
      @(posedge clock);
      {ser_addr_valid, ser_addr, ser_data_valid, ser_data} <= {1'b1, 8'h5a, 1'b1, 8'ha5};
      @(posedge clock);
      {ser_addr_valid, ser_data_valid} <= 2'b00;
      rd(A_TA, 32'h5a);
      rd(A_TD, 32'ha5);
      // operating modes: state, lock, config pick
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, A_M0, m0v[i]);
         cyc(3);
         chk(32'({rx_state, queue_lock_en, use_cfg_b}), 32'(mexp[i]));
      end
      acc(1'b1, A_M0, 8'h02);
      acc(1'b1, A_M1, 8'h50);
      cyc(3);
      chk(32'({cfg_hold, crystal_trim_on, rx_running}), 32'h7);
      // received data routed to clock and run pins
      acc(1'b1, A_M1, 8'h05);
      for (int v = 1; v >= 0; v--) begin
         @(posedge clock);
         rx_data <= v[0];
         cyc(8);
         chk(32'({clock_data_pin, run_data_pin}), 32'(v[0] ? 2'b11 : 2'b00));
      end
      // masked irq follows polarity, unmasked flag asserts it
      acc(1'b1, A_MK, 8'hff);
      acc(1'b1, A_M1, 8'h20);
      cyc(3);
      chk(32'(irq_strobe_pin), 32'h0);
      acc(1'b1, A_M1, 8'h00);
      cyc(3);
      chk(32'(irq_strobe_pin), 32'h1);
      acc(1'b1, A_MK, 8'h00);
      @(posedge clock);
      event_in <= 8'h10;
      @(posedge clock);
      event_in <= 8'h00;
      cyc(3);
      chk(32'(irq_strobe_pin), 32'h0);
      // strobe routed to the irq pin
      acc(1'b1, A_M1, 8'h02);
      @(posedge clock);
      rx_strobe <= 1'b1;
      cyc(8);
      chk(32'(irq_strobe_pin), 32'h1);
      // clock output gated by its enable bit
      acc(1'b1, A_M1, 8'h00);
      clk_src <= 1'b1;
      cyc(8);
      chk(32'(clock_data_pin), 32'h0);
      acc(1'b1, A_M0, 8'h40);
      cyc(3);
      chk(32'(clock_data_pin), 32'h1);
      // polling wake-up starts run with queue init
      acc(1'b1, A_M0, 8'h85);
      cyc(3);
      chk(32'(rx_state), 32'(CMR_POLL));
      @(posedge clock);
      event_in <= 8'h10;
      @(posedge clock);
      event_in <= 8'h00;
      #1;
      chk(32'({rx_state, queue_init}), 32'h7);
      // dual config moves to B on cycle start
      @(posedge clock);
      cycle_start <= 1'b1;
      cyc(8);
      chk(32'(use_cfg_b), 32'h1);
      @(posedge clock);
      cycle_start <= 1'b0;
      // sync timeout returns run to polling
      acc(1'b1, A_M0, 8'ha5);
      cyc(CMR_SYNC_TO_CYC / 2);
      chk(32'(rx_state), 32'(CMR_POLL_RUN));
      cyc(CMR_SYNC_TO_CYC / 2 + 20);
      chk(32'(rx_state), 32'(CMR_POLL));
      // frame start gives exactly one init pulse
      acc(1'b1, A_M1, 8'h08);
      @(posedge clock);
      frame_start <= 1'b1;
      k = 0;
      repeat (10) begin
         @(posedge clock);
         #1;
         if (queue_init === 1'b1) k++;
      end
      chk(32'(k), 32'h1);
      test_done();
   end
endmodule
